// File: logic/mesh_stop_defs.vh
`ifndef MESH_STOP_DEFS_VH
`define MESH_STOP_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_EVENT_SELECT 8'h00
`define OFS_LAST_INC 8'h04
`define OFS_RUN_TOTAL 8'h08
`define OFS_RING_STATUS 8'h0C

// ----------------------------------------------------------------
// event select fields and reset value
// ----------------------------------------------------------------
`define SEL_CODE_LSB 0
`define SEL_CODE_MSB 7
`define SEL_MASK_LSB 8
`define SEL_MASK_MSB 15
`define EVENT_SELECT_RST 16'h0000

// ----------------------------------------------------------------
// event codes
// ----------------------------------------------------------------
`define EV_AG0_REQ_TAKEN 8'h80
`define EV_AG0_REQ_HELD 8'h82
`define EV_AG1_REQ_TAKEN 8'h84
`define EV_AG1_REQ_HELD 8'h86
`define EV_AG0_DATA_TAKEN 8'h88
`define EV_AG0_DATA_HELD 8'h8A
`define EV_AG1_DATA_TAKEN 8'h8C
`define EV_AG1_DATA_HELD 8'h8E
`define EV_DISTRESS 8'hA5
`define EV_HORIZ_REQ_BUSY 8'hA7
`define EV_EGRESS_ORDER 8'hAE
`define EV_STOP_TICK 8'hC0

// ----------------------------------------------------------------
// unit mask bit positions and values
// ----------------------------------------------------------------
`define MASK_ORDER_UP 3'h0
`define MASK_ORDER_DOWN 3'h2
`define MASK_DISTRESS_VERT 8'h01
`define MASK_DISTRESS_HORIZ 8'h02
`define MASK_LEFT_EVEN 0
`define MASK_LEFT_ODD 1
`define MASK_RIGHT_EVEN 2
`define MASK_RIGHT_ODD 3

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define PORT_COUNT 6
`define HELD_WIDTH 4
`define INC_WIDTH 8

`endif

// File: logic/ahb_reg_port.v
`timescale 1ns/1ps
`include "mesh_stop_defs.vh"

// zero-wait ahb-lite slave; register storage lives in the caller
module ahb_reg_port (
   input wire core_clk,
   input wire rst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hwdata,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   output reg wr_stb,
   output reg [7:0] wr_addr,
   output wire [31:0] wr_data,
   output wire [7:0] rd_addr,
   input wire [31:0] rd_word
);

   wire take;

   // only single word transfers are taken; other hsize values are ignored
   assign take = hsel & htrans[1] & hready & (hsize == 3'h2);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wr_data = hwdata;
   assign rd_addr = haddr[7:0];

   // read data is captured at the address phase and shown in the data phase
   always @(posedge core_clk) begin
      if (rst) begin
         hrdata <= 32'h00000000;
         wr_stb <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_stb <= take & hwrite;
         if (take) begin
            wr_addr <= haddr[7:0];
         end
         if (take & ~hwrite) begin
            hrdata <= rd_word;
         end
      end
   end

endmodule

// File: logic/credit_port_sum.v
`timescale 1ns/1ps
`include "mesh_stop_defs.vh"

// per-port credit reduction: or of acquisitions, sum of occupancies
module credit_port_sum (
   input wire [5:0] port_sel,
   input wire [5:0] taken,
   input wire [23:0] held,
   output wire taken_any,
   output wire [7:0] held_sum
);

   wire [7:0] part [0:6];

   assign part[0] = 8'h00;

   // adder chain keeps each port's count at full width before summing
   genvar i;
   generate
      for (i = 0; i < 6; i = i + 1) begin : g_port
         assign part[i+1] = part[i] +
            (port_sel[i] ? {4'h0, held[4*i+3:4*i]} : 8'h00);
      end
   endgenerate

   assign taken_any = |(taken & port_sel);
   assign held_sum = part[6];

endmodule

// File: logic/mesh_stop_event_monitor.v
// Overview of operation
// - code 80h reports agent zero request-ring credits acquired per selected port.
// - mask bits 8 to 13 pick ports 0 to 5; acquisitions are ORed.
// - code 82h reports agent zero request-ring credits in use per port.
// - occupancy events add the in-use counts of all selected ports.
// - code 88h reports agent zero data-ring credits acquired per port.
// - code 8Ah reports agent zero data-ring credits in use per port.
// - code 84h reports agent one request-ring credits acquired per port.
// - code 86h reports agent one request-ring credits in use per port.
// - code 8Eh reports agent one data-ring credits in use per port.
// - code 8Ch reports agent one data-ring credits acquired per port.
// - code AEh counts ordering-blocked cycles; mask bit 0 up, bit 2 down.
// - code A5h counts distress cycles; mask 01h vertical, 02h horizontal.
// - incoming distress combines up, down and across neighbours.
// - code A7h counts horizontal request ring busy; four side/parity bits.
// - ring busy covers pass-through and sunk packets, never own injections.
// - left side maps up to clockwise; right side reverses it.
// - first half of the agents sit left, the second half right.
`timescale 1ns/1ps
`include "mesh_stop_defs.vh"

module mesh_stop_event_monitor #(
   parameter STOP_INDEX = 0,
   parameter AGENT_COUNT = 4
) (
   input wire core_clk,
   input wire rst,
   // ahb-lite register port
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hwdata,
   output wire hreadyout,
   output wire hresp,
   output wire [31:0] hrdata,
   // credit activity, one bit or one 4-bit count per transgress port
   input wire [5:0] agent0_req_credit_taken,
   input wire [23:0] agent0_req_credit_held,
   input wire [5:0] agent0_data_credit_taken,
   input wire [23:0] agent0_data_credit_held,
   input wire [5:0] agent1_req_credit_taken,
   input wire [23:0] agent1_req_credit_held,
   input wire [5:0] agent1_data_credit_taken,
   input wire [23:0] agent1_data_credit_held,
   // invalidate ring egress ordering blocks
   input wire order_block_up,
   input wire order_block_down,
   // distress wires
   input wire local_distress_vert,
   input wire local_distress_horiz,
   input wire distress_in_up,
   input wire distress_in_down,
   input wire distress_in_across,
   // horizontal request ring activity, bit 0 even ring, bit 1 odd ring
   input wire [1:0] cw_pass,
   input wire [1:0] cw_sink,
   input wire [1:0] cw_inject,
   input wire [1:0] ccw_pass,
   input wire [1:0] ccw_sink,
   input wire [1:0] ccw_inject,
   // increment towards the counter logic
   output wire [7:0] event_inc
);

   // ----------------------------------------------------------------
   // stop placement
   // ----------------------------------------------------------------

   // the first half of the agents is on the left side
   localparam ON_LEFT = (STOP_INDEX < (AGENT_COUNT / 2)) ? 1'b1 : 1'b0;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------

   reg [15:0] event_select_r;
   reg [7:0] inc_r;
   reg [7:0] inc_nxt;
   reg [31:0] total_r;
   reg [31:0] total_nxt;
   reg [31:0] rd_word;

   wire wr_stb;
   wire [7:0] wr_addr;
   wire [31:0] wr_data;
   wire [7:0] rd_addr;
   wire [7:0] sel_code;
   wire [7:0] sel_mask;
   wire [5:0] port_sel;

   wire a0r_any;
   wire [7:0] a0r_sum;
   wire a0d_any;
   wire [7:0] a0d_sum;
   wire a1r_any;
   wire [7:0] a1r_sum;
   wire a1d_any;
   wire [7:0] a1d_sum;

   wire distress_incoming;
   wire distress_vert;
   wire distress_horiz;
   wire [1:0] cw_busy;
   wire [1:0] ccw_busy;
   wire [1:0] up_busy;
   wire [1:0] down_busy;
   wire [1:0] ring_used;
   wire [3:0] horiz_hits;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // single-bit pick from the unit mask, used by the egress ordering event
   function mask_bit;
      input [7:0] mask;
      input [2:0] pos;
      begin
         mask_bit = mask[pos];
      end
   endfunction

   // widen a one-cycle condition to an increment of one
   function [7:0] one_if;
      input cond;
      begin
         one_if = cond ? 8'h01 : 8'h00;
      end
   endfunction

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------

   ahb_reg_port u_bus (
      .core_clk(core_clk),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hready(hready),
      .hwdata(hwdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .wr_stb(wr_stb),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .rd_addr(rd_addr),
      .rd_word(rd_word)
   );

   // read mux; unmapped offsets read as zero
   always @* begin
      case (rd_addr)
         `OFS_EVENT_SELECT: rd_word = {16'h0000, event_select_r};
         `OFS_LAST_INC: rd_word = {24'h000000, inc_r};
         `OFS_RUN_TOTAL: rd_word = total_r;
         `OFS_RING_STATUS: rd_word = {27'h0000000, up_busy, down_busy, ON_LEFT};
         default: rd_word = 32'h00000000;
      endcase
   end

   assign sel_code = event_select_r[`SEL_CODE_MSB:`SEL_CODE_LSB];
   assign sel_mask = event_select_r[`SEL_MASK_MSB:`SEL_MASK_LSB];
   assign port_sel = sel_mask[5:0];

   // ----------------------------------------------------------------
   // transgress credit reduction
   // ----------------------------------------------------------------

   // one reducer per agent and ring; only the selected code's result is used
   credit_port_sum u_a0_req (
      .port_sel(port_sel),
      .taken(agent0_req_credit_taken),
      .held(agent0_req_credit_held),
      .taken_any(a0r_any),
      .held_sum(a0r_sum)
   );

   credit_port_sum u_a0_data (
      .port_sel(port_sel),
      .taken(agent0_data_credit_taken),
      .held(agent0_data_credit_held),
      .taken_any(a0d_any),
      .held_sum(a0d_sum)
   );

   credit_port_sum u_a1_req (
      .port_sel(port_sel),
      .taken(agent1_req_credit_taken),
      .held(agent1_req_credit_held),
      .taken_any(a1r_any),
      .held_sum(a1r_sum)
   );

   credit_port_sum u_a1_data (
      .port_sel(port_sel),
      .taken(agent1_data_credit_taken),
      .held(agent1_data_credit_held),
      .taken_any(a1d_any),
      .held_sum(a1d_sum)
   );

   // ----------------------------------------------------------------
   // distress wires
   // ----------------------------------------------------------------

   // all three neighbours feed the incoming term
   assign distress_incoming = distress_in_up | distress_in_down | distress_in_across;
   assign distress_vert = local_distress_vert | distress_incoming;
   assign distress_horiz = local_distress_horiz | distress_incoming;

   // ----------------------------------------------------------------
   // horizontal request ring
   // ----------------------------------------------------------------

   // own injections are left out, they are not ring traffic seen here
   assign cw_busy = cw_pass | cw_sink;
   assign ccw_busy = ccw_pass | ccw_sink;

   // up and down swap rings between the two sides
   assign up_busy = ON_LEFT ? cw_busy : ccw_busy;
   assign down_busy = ON_LEFT ? ccw_busy : cw_busy;
   assign ring_used = up_busy | down_busy;

   // a side bit only hits when this stop sits on that side
   assign horiz_hits[`MASK_LEFT_EVEN] = ON_LEFT & ring_used[0];
   assign horiz_hits[`MASK_LEFT_ODD] = ON_LEFT & ring_used[1];
   assign horiz_hits[`MASK_RIGHT_EVEN] = ~ON_LEFT & ring_used[0];
   assign horiz_hits[`MASK_RIGHT_ODD] = ~ON_LEFT & ring_used[1];

   // ----------------------------------------------------------------
   // event selection
   // ----------------------------------------------------------------

   // per-cycle increment for the chosen event; default gives zero
   always @* begin
      inc_nxt = 8'h00;
      case (sel_code)
         `EV_AG0_REQ_TAKEN: inc_nxt = one_if(a0r_any);
         `EV_AG0_REQ_HELD: inc_nxt = a0r_sum;
         `EV_AG0_DATA_TAKEN: inc_nxt = one_if(a0d_any);
         `EV_AG0_DATA_HELD: inc_nxt = a0d_sum;
         `EV_AG1_REQ_TAKEN: inc_nxt = one_if(a1r_any);
         `EV_AG1_REQ_HELD: inc_nxt = a1r_sum;
         `EV_AG1_DATA_TAKEN: inc_nxt = one_if(a1d_any);
         `EV_AG1_DATA_HELD: inc_nxt = a1d_sum;
         `EV_EGRESS_ORDER: begin
            inc_nxt = one_if((mask_bit(sel_mask, `MASK_ORDER_UP) & order_block_up) |
               (mask_bit(sel_mask, `MASK_ORDER_DOWN) & order_block_down));
         end
         `EV_DISTRESS: begin
            // the mask is an exact value, not a set of bits
            if (sel_mask == `MASK_DISTRESS_VERT) begin
               inc_nxt = one_if(distress_vert);
            end else if (sel_mask == `MASK_DISTRESS_HORIZ) begin
               inc_nxt = one_if(distress_horiz);
            end else begin
               inc_nxt = 8'h00;
            end
         end
         `EV_HORIZ_REQ_BUSY: inc_nxt = one_if(|(horiz_hits & sel_mask[3:0]));
         `EV_STOP_TICK: inc_nxt = 8'h01;
         default: inc_nxt = 8'h00;
      endcase
   end

   // a clear in the same cycle as an increment keeps the increment
   always @* begin
      if (wr_stb && (wr_addr == `OFS_RUN_TOTAL)) begin
         total_nxt = {24'h000000, inc_r};
      end else begin
         total_nxt = total_r + {24'h000000, inc_r};
      end
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------

   // increment is registered so the counter sees a clean value
   always @(posedge core_clk) begin
      if (rst) begin
         event_select_r <= `EVENT_SELECT_RST;
         inc_r <= 8'h00;
         total_r <= 32'h00000000;
      end else begin
         inc_r <= inc_nxt;
         total_r <= total_nxt;
         if (wr_stb && (wr_addr == `OFS_EVENT_SELECT)) begin
            event_select_r <= wr_data[15:0];
         end
      end
   end

   assign event_inc = inc_r;

endmodule

// File: verif/count_sink.sv
`timescale 1ns/1ps
// --------
// counter-side partner: accumulates every increment offered
// --------
module count_sink (
   input wire core_clk,
   input wire rst,
   input wire [7:0] event_inc,
   output logic [31:0] total
);
   // no enable, so a stuck increment shows up as drift in the total
   always @(posedge core_clk) begin
      if (rst) begin
         total <= 32'h00000000;
      end else begin
         total <= total + {24'h000000, event_inc};
      end
   end
endmodule

// File: verif/mesh_stop_event_monitor_properties.sv
`timescale 1ns/1ps
// --------
// select shadow and event checks
// --------
module mesh_stop_event_monitor_properties #(
   parameter STOP_INDEX = 0,
   parameter AGENT_COUNT = 4
) (
   input wire core_clk,
   input wire rst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hreadyout,
   input wire hresp,
   input wire [5:0] agent0_req_credit_taken,
   input wire [23:0] agent0_req_credit_held,
   input wire [5:0] agent0_data_credit_taken,
   input wire [23:0] agent1_data_credit_held,
   input wire order_block_up,
   input wire order_block_down,
   input wire local_distress_vert,
   input wire local_distress_horiz,
   input wire distress_in_up,
   input wire distress_in_down,
   input wire distress_in_across,
   input wire [1:0] cw_pass,
   input wire [1:0] cw_sink,
   input wire [1:0] ccw_pass,
   input wire [1:0] ccw_sink,
   input wire [7:0] event_inc
);
   logic wr_pend_r;
   logic [7:0] code_r;
   logic [7:0] mask_r;
   wire din = distress_in_up | distress_in_down | distress_in_across;
   wire [1:0] busy = cw_pass | cw_sink | ccw_pass | ccw_sink;
   wire [3:0] hits = (STOP_INDEX < AGENT_COUNT / 2) ? {2'b00, busy} : {busy, 2'b00};

   // sum of in-use counts over the selected ports
   function automatic [7:0] hsum(input [23:0] h, input [7:0] m);
      hsum = 8'h00;
      for (int i = 0; i < 6; i++) begin
         if (m[i]) hsum = hsum + {4'h0, h[4*i +: 4]};
      end
   endfunction

   // shadow of the select register; only whole completed writes count
   always @(posedge core_clk) begin
      if (rst) begin
         wr_pend_r <= 1'b0;
         code_r <= 8'h00;
         mask_r <= 8'h00;
      end else begin
         wr_pend_r <= hsel && htrans[1] && hwrite && hreadyout && (haddr[7:0] == 8'h00);
         if (wr_pend_r) begin
            code_r <= hwdata[7:0];
            mask_r <= hwdata[15:8];
         end
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_req0_held: assert property (
      $past(code_r) == 8'h82 && !$past(rst) |->
      event_inc == $past(hsum(agent0_req_credit_held, mask_r))) else $error("occupancy sum wrong");
   chk_req0_taken: assert property (
      $past(code_r) == 8'h80 && !$past(rst) |->
      event_inc == {7'h00, $past(|(agent0_req_credit_taken & mask_r[5:0]))})
      else $error("request credit or wrong");
   chk_data0_taken: assert property (
      $past(code_r) == 8'h88 && !$past(rst) |->
      event_inc == {7'h00, $past(|(agent0_data_credit_taken & mask_r[5:0]))})
      else $error("data credit or wrong");
   chk_data1_held: assert property (
      $past(code_r) == 8'h8E && !$past(rst) |->
      event_inc == $past(hsum(agent1_data_credit_held, mask_r))) else $error("data sum wrong");
   chk_order_block: assert property (
      $past(code_r) == 8'hAE && !$past(rst) |-> event_inc ==
      {7'h00, $past(mask_r[0] & order_block_up | mask_r[2] & order_block_down)})
      else $error("ordering block count wrong");
   chk_distress_wire: assert property (
      $past(code_r) == 8'hA5 && !$past(rst) |-> event_inc ==
      {7'h00, $past(mask_r == 8'h01 && (local_distress_vert || din) ||
      mask_r == 8'h02 && (local_distress_horiz || din))}) else $error("distress count wrong");
   chk_ring_busy: assert property (
      $past(code_r) == 8'hA7 && !$past(rst) |->
      event_inc == {7'h00, $past(|(hits & mask_r[3:0]))}) else $error("ring busy wrong");
   chk_tick_one: assert property (
      $past(code_r) == 8'hC0 && !$past(rst) |-> event_inc == 8'h01) else $error("tick wrong");
   chk_unknown_zero: assert property (
      !($past(code_r) inside {8'h80, 8'h82, 8'h84, 8'h86, 8'h88, 8'h8A, 8'h8C, 8'h8E,
      8'hA5, 8'hA7, 8'hAE, 8'hC0}) && !$past(rst) |-> event_inc == 8'h00)
      else $error("unknown code counted");
endmodule

bind mesh_stop_event_monitor mesh_stop_event_monitor_properties #(
   .STOP_INDEX(STOP_INDEX),
   .AGENT_COUNT(AGENT_COUNT)
) chk_i (.*);

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   // --------
   // stimulus signals and design hookup
   // --------
   localparam logic [23:0] H0R = 24'h654321, H1R = 24'h0F0F0F, H0D = 24'hFEDCBA, H1D = 24'h987654;
   localparam logic [5:0] T0R = 6'h04, T1R = 6'h01, T0D = 6'h20, T1D = 6'h10;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic hsel, hwrite;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata;
   logic [5:0] agent0_req_credit_taken, agent0_data_credit_taken;
   logic [5:0] agent1_req_credit_taken, agent1_data_credit_taken;
   logic [23:0] agent0_req_credit_held, agent0_data_credit_held;
   logic [23:0] agent1_req_credit_held, agent1_data_credit_held;
   logic order_block_up, order_block_down, local_distress_vert, local_distress_horiz;
   logic distress_in_up, distress_in_down, distress_in_across;
   logic [1:0] cw_pass, cw_sink, cw_inject, ccw_pass, ccw_sink, ccw_inject;
   wire hready, hreadyout, hresp;
   wire [31:0] hrdata, total;
   wire [7:0] event_inc;
   wire [31:0] side_hrdata;
   wire [7:0] side_inc;
   int fail_count = 0;
   int n_checks = 0;

   assign hready = hreadyout;
   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;
   mesh_stop_event_monitor #(.STOP_INDEX(0), .AGENT_COUNT(4)) DUT (.*);
   // a second stop on the right half, so the up/down swap is seen at all
   mesh_stop_event_monitor #(.STOP_INDEX(2), .AGENT_COUNT(4)) right_stop (.*, .hreadyout(),
      .hresp(), .hrdata(side_hrdata), .event_inc(side_inc));
   count_sink u_sink (.core_clk(core_clk), .rst(rst), .event_inc(event_inc), .total(total));

   // --------
   // shared tasks
   // --------
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // bounded wait so a stuck slave ends the run instead of hanging it
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         fail_count++;
         stop_test();
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h000000, a};
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask

   // select an event, then judge the increment one cycle later
   task automatic run(input logic [7:0] code, input logic [7:0] m, input logic [7:0] exp);
      logic [31:0] q;
      bus(1'b1, 8'h00, {16'h0000, m, code}, q);
      @(posedge core_clk);
      #1;
      check({24'h000000, event_inc}, {24'h000000, exp});
   endtask

   task automatic dset(input logic [4:0] v);
      @(posedge core_clk);
      {local_distress_vert, local_distress_horiz, distress_in_up, distress_in_down,
       distress_in_across} <= v;
   endtask

   task automatic rset(input logic [11:0] v);
      @(posedge core_clk);
      {cw_pass, cw_sink, cw_inject, ccw_pass, ccw_sink, ccw_inject} <= v;
   endtask

   function automatic logic [7:0] exp_credit(input logic [7:0] code, input logic [7:0] m);
      logic [23:0] h;
      logic [5:0] t;
      logic [7:0] s;
      h = code[3] ? (code[2] ? H1D : H0D) : (code[2] ? H1R : H0R);
      t = code[3] ? (code[2] ? T1D : T0D) : (code[2] ? T1R : T0R);
      s = 8'h00;
      for (int i = 0; i < 6; i++) begin
         if (m[i]) s = s + {4'h0, h[4*i +: 4]};
      end
      return code[1] ? s : {7'h00, |(t & m[5:0])};
   endfunction

   // --------
   // scenarios
   // --------
   task automatic s_credit;
      logic [7:0] masks[3] = '{8'h05, 8'h3F, 8'hC0};
      logic [7:0] code;
      logic [7:0] m;
      @(posedge core_clk);
      {agent0_req_credit_taken, agent1_req_credit_taken} <= {T0R, T1R};
      {agent0_data_credit_taken, agent1_data_credit_taken} <= {T0D, T1D};
      {agent0_req_credit_held, agent1_req_credit_held} <= {H0R, H1R};
      {agent0_data_credit_held, agent1_data_credit_held} <= {H0D, H1D};
      // eight credit codes, three masks each
      for (int n = 0; n < 24; n++) begin
         code = 8'h80 + 8'(2 * (n / 3));
         m = masks[n % 3];
         run(code, m, exp_credit(code, m));
      end
   endtask

   task automatic s_order;
      @(posedge core_clk);
      {order_block_up, order_block_down} <= 2'b10;
      run(8'hAE, 8'h01, 8'h01);
      run(8'hAE, 8'h04, 8'h00);
      @(posedge core_clk);
      {order_block_up, order_block_down} <= 2'b01;
      run(8'hAE, 8'h04, 8'h01);
   endtask

   task automatic s_distress;
      dset(5'b00001);
      run(8'hA5, 8'h01, 8'h01);
      run(8'hA5, 8'h03, 8'h00);
      dset(5'b00100);
      run(8'hA5, 8'h02, 8'h01);
      dset(5'b00010);
      run(8'hA5, 8'h01, 8'h01);
      dset(5'b01000);
      run(8'hA5, 8'h01, 8'h00);
      run(8'hA5, 8'h02, 8'h01);
      dset(5'b10000);
      run(8'hA5, 8'h01, 8'h01);
      run(8'hA5, 8'h02, 8'h00);
   endtask

   task automatic s_ring;
      logic [31:0] q;
      rset({2'b01, 2'b00, 2'b11, 2'b00, 2'b00, 2'b11});
      run(8'hA7, 8'h01, 8'h01);
      check({24'h000000, side_inc}, 32'h00000000);
      run(8'hA7, 8'h02, 8'h00);
      run(8'hA7, 8'h04, 8'h00);
      check({24'h000000, side_inc}, 32'h00000001);
      bus(1'b0, 8'h0C, 32'h00000000, q);
      check(q, 32'h00000009);
      check(side_hrdata, 32'h00000002);
      rset({2'b00, 2'b00, 2'b11, 2'b00, 2'b10, 2'b11});
      run(8'hA7, 8'h02, 8'h01);
      bus(1'b0, 8'h0C, 32'h00000000, q);
      check(q, 32'h00000005);
      check(side_hrdata, 32'h00000010);
   endtask

   task automatic s_misc;
      logic [31:0] q;
      logic [31:0] t0;
      check({24'h000000, event_inc}, 32'h00000000);
      run(8'hC0, 8'h00, 8'h01);
      t0 = total;
      repeat (10) @(posedge core_clk);
      #1;
      check(total - t0, 32'h0000000A);
      bus(1'b0, 8'h04, 32'h00000000, q);
      check(q, 32'h00000001);
      // a clear keeps that cycle's tick, and one more tick lands before the read
      bus(1'b1, 8'h08, 32'h00000000, q);
      bus(1'b0, 8'h08, 32'h00000000, q);
      check(q, 32'h00000002);
      run(8'h81, 8'hFF, 8'h00);
      bus(1'b0, 8'h00, 32'h00000000, q);
      check(q, 32'h0000FF81);
      bus(1'b0, 8'h40, 32'h00000000, q);
      check(q, 32'h00000000);
   endtask

   // reset held two cycles, then every scenario in turn
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      {agent0_req_credit_taken, agent0_data_credit_taken, agent1_req_credit_taken} = '0;
      {agent1_data_credit_taken, agent0_req_credit_held, agent0_data_credit_held} = '0;
      {agent1_req_credit_held, agent1_data_credit_held, order_block_up, order_block_down} = '0;
      {local_distress_vert, local_distress_horiz, distress_in_up, distress_in_down} = '0;
      {distress_in_across, cw_pass, cw_sink, cw_inject, ccw_pass, ccw_sink, ccw_inject} = '0;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      s_misc();
      s_credit();
      s_order();
      s_distress();
      s_ring();
      stop_test();
   end
endmodule
